// ---- dv/panel_host_model.sv ----
// Host side model: register strobes and the recommended start-up writes
`default_nettype none
module panel_host_model (
  input wire logic sys_clk_in,
  input wire logic [15:0] reg_rdata_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [15:0] reg_index_out,
  output logic [15:0] reg_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Gamma words sent at start-up, low field in bits 5:0, high field in bits 13:8
  logic [15:0] init_vals [16] = '{16'h0101, 16'h0B2C, 16'h1030, 16'h3010, 16'h2C0B, 16'h0101,
    16'h0807, 16'h0708, 16'h0107, 16'h0105, 16'h0F04, 16'h0F00, 16'h000F, 16'h040F,
    16'h0501, 16'h0701};
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_index_out = 16'h0000;
    reg_data_out = 16'h0000;
  end
  // One strobe per call; index and data turn over after it so stale values never match
  task automatic write_reg(input logic [15:0] idx, input logic [15:0] dat);
    @(negedge sys_clk_in);
    reg_index_out = idx;
    reg_data_out = dat;
    reg_wr_out = 1'b1;
    @(negedge sys_clk_in);
    reg_wr_out = 1'b0;
    reg_index_out = ~idx;
    reg_data_out = ~dat;
  endtask : write_reg
  // Read data is taken two falling edges after the read strobe is raised
  task automatic read_reg(input logic [15:0] idx, output logic [15:0] dat);
    @(negedge sys_clk_in);
    reg_index_out = idx;
    reg_rd_out = 1'b1;
    @(negedge sys_clk_in);
    reg_rd_out = 1'b0;
    reg_index_out = ~idx;
    @(negedge sys_clk_in);
    dat = reg_rdata_in;
  endtask : read_reg
  // Power write, settle delay of 1000 cycles at 100 MHz, gamma words, display on last
  task automatic init_seq();
    write_reg(16'h0606, 16'h0000);
    repeat (1000) @(negedge sys_clk_in);
    for (int j = 0; j < 16; j++) begin
      write_reg(16'h0300 + 16'(j), init_vals[j]);
    end
    write_reg(16'h0007, 16'h0173);
  endtask : init_seq
endmodule : panel_host_model
`default_nettype wire

// ---- dv/panel_scan_partial_display_ctrl_bench.sv ----
// Self-checking bench: scan orders, partial windows, frame marker and gamma trims
`default_nettype none
module panel_scan_partial_display_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LC = 4;
  localparam int PL = 2;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  panel_scan_pkg::scan_cfg_t scan_cfg = '0;
  panel_scan_pkg::marker_cfg_t marker_cfg = '0;
  panel_scan_pkg::part_cfg_t part_cfg = '0;
  logic reg_wr, reg_rd, frame_marker, line_strobe, marker_q;
  logic [15:0] reg_index, reg_data, reg_rdata;
  panel_scan_pkg::line_info_t line_info;
  logic [15:0][5:0] pos_trim, neg_trim;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int gst[$];
  int mr[$];
  int mf[$];
  panel_scan_pkg::line_info_t gq[$];

  always #5 sys_clk_in = ~sys_clk_in;

  panel_scan_partial_display_ctrl #(.LINE_CYCLES(LC), .PORCH_LINES(PL))
    panel_scan_partial_display_ctrl_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .scan_cfg_in(scan_cfg), .marker_cfg_in(marker_cfg), .part_cfg_in(part_cfg),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_index_in(reg_index), .reg_data_in(reg_data),
    .reg_rdata_out(reg_rdata), .frame_marker_out(frame_marker), .line_strobe_out(line_strobe),
    .line_info_out(line_info), .pos_gamma_trim_out(pos_trim), .neg_gamma_trim_out(neg_trim));
  panel_host_model panel_host_model_inst (.sys_clk_in(sys_clk_in), .reg_rdata_in(reg_rdata),
    .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_index_out(reg_index),
    .reg_data_out(reg_data));

  // Stamp every strobe and marker edge with a free-running cycle count
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    marker_q <= frame_marker;
    if (line_strobe === 1'b1) begin
      gst.push_back(cyc);
      gq.push_back(line_info);
    end
    if (frame_marker === 1'b1 && marker_q !== 1'b1) mr.push_back(cyc);
    if (frame_marker !== 1'b1 && marker_q === 1'b1) mf.push_back(cyc);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Config changes only under reset, so each run starts on a clean frame
  task automatic restart(input logic [7:0] s, input logic [74:0] p, input logic [11:0] m,
                         input int need);
    @(negedge sys_clk_in);
    scan_cfg = s;
    part_cfg = p;
    marker_cfg = m;
    rst_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    gst.delete();
    gq.delete();
    mr.delete();
    mf.delete();
    rst_in = 1'b0;
    for (int t = 0; t < 20000 && (gst.size() < need || mr.size() < 3); t++)
      @(negedge sys_clk_in);
  endtask : restart

  function automatic int exp_gate(input logic [1:0] mode, input int n, input int k);
    int h;
    h = n / 2;
    case (mode)
      2'b00: return k + 1;
      2'b01: return n - k;
      2'b10: return (k < h) ? 2 * k + 1 : 2 * (k - h) + 2;
      default: return (k < h) ? n - 2 * k : n - 1 - 2 * (k - h);
    endcase
  endfunction : exp_gate

  // Shown flag and source line for row r of one line range placed at screen row d
  function automatic logic [9:0] win(input logic en, input int s, input int e, input int d,
                                     input int r);
    return (en && r >= d && r <= d + e - s) ? {1'b1, 9'(s + r - d)} : 10'h000;
  endfunction : win

  function automatic logic [9:0] exp_info(input panel_scan_pkg::part_cfg_t p, input int r);
    logic [9:0] w1;
    if (p.base_image_enable)
      return win(1'b1, p.base_start_line, p.base_end_line, p.base_start_line, r);
    w1 = win(p.window_one_enable, p.window_one_start_line, p.window_one_end_line,
             p.window_one_screen_pos, r);
    return w1[9] ? w1 : win(p.window_two_enable, p.window_two_start_line,
                            p.window_two_end_line, p.window_two_screen_pos, r);
  endfunction : exp_info

  function automatic logic [5:0] fmask(input int i);
    int w;
    w = (i == 0 || (i >= 5 && i <= 7)) ? 5 : ((i <= 4) ? 6 : 4);
    return 6'((1 << w) - 1);
  endfunction : fmask

  // One frame plus the first line of the next; porch lines must carry no strobe
  task automatic scan_frame(input panel_scan_pkg::scan_cfg_t s, input logic [74:0] p);
    int n;
    logic [1:0] md;
    n = (s.active_line_count >= 6'h35) ? 432 : 8 * (int'(s.active_line_count) + 1);
    md = {s.interlace_scan_select, s.gate_scan_reverse};
    restart(s, p, '0, n + 1);
    check(16'(gst.size() > n), 16'h0001);
    if (gst.size() > n) begin
      for (int k = 0; k < n; k++) begin
        check(16'(gq[k].gate_line), 16'(exp_gate(md, n, k)));
        check({6'h00, gq[k].shown, gq[k].shown ? gq[k].source_line : 9'h000},
              {6'h00, exp_info(p, int'(gq[k].gate_line) - 1)});
      end
      check(16'(gst[1] - gst[0]), 16'(LC));
      check(16'(gst[n] - gst[n - 1]), 16'((PL + 1) * LC));
      check(16'(gq[n].gate_line), 16'(exp_gate(md, n, 0)));
    end
  endtask : scan_frame

  initial begin
    logic [2:0] cs [5] = '{3'b111, 3'b010, 3'b001, 3'b011, 3'b000};
    logic [15:0] rd;
    logic [15:0] v;
    int f;
    int m0;
    int k;
    repeat (6) @(negedge sys_clk_in);
    // Every scan order over the full panel with the base image on
    for (int md = 0; md < 4; md++) begin
      scan_frame({2'(md), 6'h35}, {3'b100, 9'd0, 9'd431, 54'h0});
    end
    // Window two overlaps rows 3 of window one; its source lies past the 8 active lines
    for (int c = 0; c < 5; c++) begin
      scan_frame({2'b00, 6'h00}, {cs[c], 9'd1, 9'd3, 9'd20, 9'd21, 9'd2, 9'd100, 9'd102, 9'd3});
    end
    // Marker period spans interval+1 frames of 8 active and PL porch lines
    foreach (cs[i]) begin
      if (i < 3) begin
        restart({2'b00, 6'h00}, '0, {9'd3, 3'(i == 2 ? 7 : i)}, 1);
        check(16'(mr[1] - mr[0]), 16'(((i == 2 ? 7 : i) + 1) * (8 + PL) * LC));
        check(16'(mf[0] - mr[0]), 16'(LC));
        if (i == 0) m0 = mr[0] - gst[0];
      end
    end
    restart({2'b00, 6'h00}, '0, {9'd8, 3'd0}, 1);
    check(16'(mr[0] - gst[0] - m0), 16'(5 * LC));
    // Clock enable low freezes the line timer, so the running line grows by the frozen cycles
    for (int t = 0; t < 100 && line_strobe !== 1'b1; t++)
      @(negedge sys_clk_in);
    @(negedge sys_clk_in);
    k = gst.size();
    ce_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    ce_in = 1'b1;
    for (int t = 0; t < 100 && gst.size() <= k; t++)
      @(negedge sys_clk_in);
    check(16'(gst[k] - gst[k - 1]), 16'(LC + 10));
    // Gamma trims: reset value, start-up words, masking and readback
    panel_host_model_inst.read_reg(16'h0300, rd);
    check(rd, 16'h0000);
    panel_host_model_inst.init_seq();
    for (int j = 0; j < 16; j++) begin
      v = panel_host_model_inst.init_vals[j];
      f = (j % 8) * 2;
      panel_host_model_inst.read_reg(16'h0300 + 16'(j), rd);
      check(rd, {2'b00, v[13:8] & fmask(f + 1), 2'b00, v[5:0] & fmask(f)});
      check(16'(j < 8 ? pos_trim[f] : neg_trim[f]), 16'(v[5:0] & fmask(f)));
    end
    // Full-scale negative write must leave the positive set alone
    panel_host_model_inst.write_reg(16'h0308, 16'hFFFF);
    check(16'(neg_trim[0]), 16'h001F);
    check(16'(neg_trim[1]), 16'h003F);
    check(16'(pos_trim[0]), 16'h0001);
    panel_host_model_inst.write_reg(16'h0310, 16'hFFFF);
    panel_host_model_inst.read_reg(16'h0310, rd);
    check(rd, 16'h0000);
    panel_host_model_inst.read_reg(16'h03F0, rd);
    check(rd, 16'h0000);
    panel_host_model_inst.write_reg(16'h0300, 16'hFFFF);
    panel_host_model_inst.read_reg(16'h0300, rd);
    check(rd, 16'h3F1F);
    summarize();
  end

  // Watchdog well beyond the expected run of about 16500 cycles
  initial begin
    #600_000;
    fails++;
    summarize();
  end
endmodule : panel_scan_partial_display_ctrl_bench
`default_nettype wire

// ---- rtl/panel_scan_partial_display_ctrl.sv ----
// Gate scan sequencer, partial display mapping, frame marker and gamma trim store
`default_nettype none
module panel_scan_partial_display_ctrl #(
  parameter int unsigned LINE_CYCLES = panel_scan_pkg::LINE_CYCLES_DEF,
  parameter int unsigned PORCH_LINES = panel_scan_pkg::PORCH_LINES_DEF
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire panel_scan_pkg::scan_cfg_t scan_cfg_in,
  input wire panel_scan_pkg::marker_cfg_t marker_cfg_in,
  input wire panel_scan_pkg::part_cfg_t part_cfg_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_index_in,
  input wire logic [15:0] reg_data_in,
  output logic [15:0] reg_rdata_out,
  output logic frame_marker_out,
  output logic line_strobe_out,
  output panel_scan_pkg::line_info_t line_info_out,
  output logic [15:0][5:0] pos_gamma_trim_out,
  output logic [15:0][5:0] neg_gamma_trim_out
);
  localparam logic [15:0] LINE_LAST = 16'(LINE_CYCLES - 1);
  localparam logic [8:0] PORCH_LAST = 9'(PORCH_LINES - 1);

  panel_scan_pkg::frame_phase_t phase;
  logic [15:0] cyc;
  logic [8:0] step;
  logic [8:0] frame_line;
  logic [2:0] frame_cnt;
  logic line_tick;
  logic [8:0] active_lines;
  logic [8:0] half_lines;
  logic [8:0] next_gate;
  logic [8:0] row;
  panel_scan_pkg::line_info_t next_info;
  logic [5:0] pos_trim [panel_scan_pkg::GAMMA_FIELDS];
  logic [5:0] neg_trim [panel_scan_pkg::GAMMA_FIELDS];

  // Active lines follow the line count field in steps of eight, capped at the panel size
  always_comb begin
    if (scan_cfg_in.active_line_count >= panel_scan_pkg::LINE_COUNT_FULL_CODE) begin
      active_lines = panel_scan_pkg::PANEL_LAST_GATE;
    end else begin
      active_lines = 9'((scan_cfg_in.active_line_count + 7'd1) *
                        panel_scan_pkg::LINE_COUNT_STEP);
    end
    half_lines = {1'b0, active_lines[8:1]};
  end

  // Line timer: one gate line every LINE_CYCLES clocks
  assign line_tick = ce_in && (cyc == LINE_LAST);
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cyc <= 16'h0000;
    end else if (ce_in) begin
      cyc <= line_tick ? 16'h0000 : 16'(cyc + 16'h0001);
    end
  end

  // Frame phase machine: active lines, then porch lines with no gate driven
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= panel_scan_pkg::PH_ACTIVE;
      step <= 9'h000;
    end else if (line_tick) begin
      case (phase)
        panel_scan_pkg::PH_ACTIVE: begin
          if (step == 9'(active_lines - 9'h001)) begin
            phase <= panel_scan_pkg::PH_PORCH;
            step <= 9'h000;
          end else begin
            step <= 9'(step + 9'h001);
          end
        end
        panel_scan_pkg::PH_PORCH: begin
          if (step == PORCH_LAST) begin
            phase <= panel_scan_pkg::PH_ACTIVE;
            step <= 9'h000;
          end else begin
            step <= 9'(step + 9'h001);
          end
        end
        default: begin
          phase <= panel_scan_pkg::PH_ACTIVE;
          step <= 9'h000;
        end
      endcase
    end
  end

  // Gate number for the current step; order changes only take effect per step
  always_comb begin
    case (panel_scan_pkg::scan_order_t'({scan_cfg_in.interlace_scan_select,
                                         scan_cfg_in.gate_scan_reverse}))
      panel_scan_pkg::SCAN_ASC: next_gate = 9'(step + 9'h001);
      panel_scan_pkg::SCAN_DESC: next_gate = 9'(active_lines - step);
      panel_scan_pkg::SCAN_ILACE_ASC: begin
        if (step < half_lines) begin
          next_gate = 9'({step[7:0], 1'b0} + 9'h001);
        end else begin
          next_gate = 9'({8'(step - half_lines), 1'b0} + 9'h002);
        end
      end
      panel_scan_pkg::SCAN_ILACE_DESC: begin
        if (step < half_lines) begin
          next_gate = 9'(active_lines - {step[7:0], 1'b0});
        end else begin
          next_gate = 9'(active_lines - 9'h001 - {8'(step - half_lines), 1'b0});
        end
      end
      default: next_gate = 9'(step + 9'h001);
    endcase
    row = 9'(next_gate - 9'h001);
  end

  // Partial display mapping of one panel row; window one wins where windows overlap.
  // Source lines are checked against neither the full memory nor the active lines, so a
  // short panel may keep window images beyond its last active row.
  always_comb begin
    next_info.gate_line = next_gate;
    next_info.shown = 1'b0;
    next_info.source_line = 9'h000;
    if (part_cfg_in.base_image_enable) begin
      // Window enables are ignored here
      if (row >= part_cfg_in.base_start_line && row <= part_cfg_in.base_end_line) begin
        next_info.shown = 1'b1;
        next_info.source_line = row;
      end
    end else if (part_cfg_in.window_one_enable && row >= part_cfg_in.window_one_screen_pos &&
        9'(row - part_cfg_in.window_one_screen_pos) <=
        9'(part_cfg_in.window_one_end_line - part_cfg_in.window_one_start_line)) begin
      next_info.shown = 1'b1;
      next_info.source_line = 9'(part_cfg_in.window_one_start_line + row -
                                 part_cfg_in.window_one_screen_pos);
    end else if (part_cfg_in.window_two_enable && row >= part_cfg_in.window_two_screen_pos &&
        9'(row - part_cfg_in.window_two_screen_pos) <=
        9'(part_cfg_in.window_two_end_line - part_cfg_in.window_two_start_line)) begin
      next_info.shown = 1'b1;
      next_info.source_line = 9'(part_cfg_in.window_two_start_line + row -
                                 part_cfg_in.window_two_screen_pos);
    end
  end

  // Registered line outputs, strobe for one clock per driven gate line
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      line_info_out <= '0;
      line_strobe_out <= 1'b0;
    end else if (ce_in) begin
      line_strobe_out <= line_tick && (phase == panel_scan_pkg::PH_ACTIVE);
      if (line_tick && phase == panel_scan_pkg::PH_ACTIVE) begin
        line_info_out <= next_info;
      end
    end
  end

  // Frame line position and frame interval counters for the marker
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_line <= 9'h000;
      frame_cnt <= 3'h0;
    end else if (line_tick) begin
      if (phase == panel_scan_pkg::PH_PORCH && step == PORCH_LAST) begin
        frame_line <= 9'h000;
        frame_cnt <= (frame_cnt >= marker_cfg_in.marker_repeat_interval) ?
                     3'h0 : 3'(frame_cnt + 3'h1);
      end else begin
        frame_line <= 9'(frame_line + 9'h001);
      end
    end
  end

  // Marker held for the whole line at the set position, only on every (interval+1)th frame
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_marker_out <= 1'b0;
    end else if (ce_in) begin
      frame_marker_out <= (frame_line == marker_cfg_in.marker_line_position) &&
                          (frame_cnt == 3'h0);
    end
  end

  // Gamma trim store: two fields per word, positive then negative block
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < panel_scan_pkg::GAMMA_FIELDS; i++) begin
        pos_trim[i] <= panel_scan_pkg::TRIM_RESET;
        neg_trim[i] <= panel_scan_pkg::TRIM_RESET;
      end
    end else if (ce_in && reg_wr_in && reg_index_in >= panel_scan_pkg::GAMMA_FIRST_IDX &&
        reg_index_in <= panel_scan_pkg::GAMMA_LAST_IDX) begin
      for (int j = 0; j < panel_scan_pkg::GAMMA_WORDS; j++) begin
        if (reg_index_in == 16'(panel_scan_pkg::GAMMA_FIRST_IDX + j)) begin
          pos_trim[2*j] <= reg_data_in[panel_scan_pkg::TRIM_LO_BIT +: 6] &
                           panel_scan_pkg::trim_mask(4'(2*j));
          pos_trim[2*j+1] <= reg_data_in[panel_scan_pkg::TRIM_HI_BIT +: 6] &
                             panel_scan_pkg::trim_mask(4'(2*j+1));
        end
        if (reg_index_in == 16'(panel_scan_pkg::GAMMA_NEG_IDX + j)) begin
          neg_trim[2*j] <= reg_data_in[panel_scan_pkg::TRIM_LO_BIT +: 6] &
                           panel_scan_pkg::trim_mask(4'(2*j));
          neg_trim[2*j+1] <= reg_data_in[panel_scan_pkg::TRIM_HI_BIT +: 6] &
                             panel_scan_pkg::trim_mask(4'(2*j+1));
        end
      end
    end
  end

  // Read back a trim word one clock after the read request; other indices read zero
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (ce_in && reg_rd_in) begin
      reg_rdata_out <= 16'h0000;
      for (int j = 0; j < panel_scan_pkg::GAMMA_WORDS; j++) begin
        if (reg_index_in == 16'(panel_scan_pkg::GAMMA_FIRST_IDX + j)) begin
          reg_rdata_out <= {2'b00, pos_trim[2*j+1], 2'b00, pos_trim[2*j]};
        end
        if (reg_index_in == 16'(panel_scan_pkg::GAMMA_NEG_IDX + j)) begin
          reg_rdata_out <= {2'b00, neg_trim[2*j+1], 2'b00, neg_trim[2*j]};
        end
      end
    end
  end

  // Trim fields presented to the gamma generator straight from the store
  always_comb begin
    for (int i = 0; i < panel_scan_pkg::GAMMA_FIELDS; i++) begin
      pos_gamma_trim_out[i] = pos_trim[i];
      neg_gamma_trim_out[i] = neg_trim[i];
    end
  end

  // Helper: gate of the previous strobe and the order it was produced in
  logic [8:0] prev_gate;
  logic [1:0] prev_order;
  logic prev_valid;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_gate <= 9'h000;
      prev_order <= 2'b00;
      prev_valid <= 1'b0;
    end else if (line_strobe_out && ce_in) begin
      prev_gate <= line_info_out.gate_line;
      prev_order <= {scan_cfg_in.interlace_scan_select, scan_cfg_in.gate_scan_reverse};
      prev_valid <= 1'b1;
    end
  end

  wire logic [1:0] cur_order = {scan_cfg_in.interlace_scan_select,
                                scan_cfg_in.gate_scan_reverse};
  wire logic same_run = prev_valid && prev_order == cur_order && line_strobe_out;

  a_asc_step: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    same_run && cur_order == 2'b00 && line_info_out.gate_line != 9'h001 |->
      line_info_out.gate_line == 9'(prev_gate + 9'h001))
    else $error("ascending scan skipped a gate line");

  a_desc_step: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    same_run && cur_order == 2'b01 && prev_gate != 9'h001 |->
      line_info_out.gate_line == 9'(prev_gate - 9'h001))
    else $error("descending scan skipped a gate line");

  a_ilace_asc: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    same_run && cur_order == 2'b10 && line_info_out.gate_line != 9'h001 |->
      (line_info_out.gate_line == 9'(prev_gate + 9'h002)) ||
      (prev_gate[0] && line_info_out.gate_line == 9'h002))
    else $error("interlaced ascending order broken");

  a_ilace_desc: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    same_run && cur_order == 2'b11 && prev_gate != 9'h001 |->
      (line_info_out.gate_line == 9'(prev_gate - 9'h002)) ||
      (prev_gate == 9'h002 && line_info_out.gate_line[0]))
    else $error("interlaced descending order broken");

  sequence s_marker_line;
    line_tick && phase == panel_scan_pkg::PH_ACTIVE && frame_cnt == 3'h0 &&
      frame_line == 9'(marker_cfg_in.marker_line_position - 9'h001) && ce_in;
  endsequence

  a_marker_pos: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    frame_marker_out |-> $past(frame_line) == marker_cfg_in.marker_line_position)
    else $error("frame marker outside its line position");

  a_marker_rise: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_marker_line ##1 ce_in |=> frame_marker_out)
    else $error("frame marker missing at its line");

  a_base_full: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    line_tick && phase == panel_scan_pkg::PH_ACTIVE && part_cfg_in.base_image_enable &&
      row >= part_cfg_in.base_start_line && row <= part_cfg_in.base_end_line |=>
      line_info_out.shown && line_info_out.source_line == $past(row))
    else $error("base image line not shown");

  a_no_window: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    line_tick && phase == panel_scan_pkg::PH_ACTIVE && !part_cfg_in.base_image_enable &&
      !part_cfg_in.window_one_enable && !part_cfg_in.window_two_enable |=>
      !line_info_out.shown)
    else $error("line shown with every image disabled");

  a_gamma_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in && reg_wr_in && reg_index_in == panel_scan_pkg::GAMMA_FIRST_IDX |=>
      pos_gamma_trim_out[0] == ($past(reg_data_in[5:0]) & 6'h1F) &&
      pos_gamma_trim_out[1] == $past(reg_data_in[13:8]))
    else $error("first positive gamma word not stored");
endmodule : panel_scan_partial_display_ctrl
`default_nettype wire

// ---- rtl/panel_scan_pkg.sv ----
// Shared constants, types and helpers for the panel scan and partial display controller
`default_nettype none
package panel_scan_pkg;
  // Panel geometry and scan timing
  localparam int unsigned PANEL_LINES = 432;
  localparam logic [8:0] PANEL_LAST_GATE = 9'h1B0;
  localparam logic [8:0] PANEL_HALF = 9'h0D8;
  localparam logic [5:0] LINE_COUNT_FULL_CODE = 6'h35;
  localparam int unsigned LINE_COUNT_STEP = 8;
  localparam int unsigned LINE_CYCLES_DEF = 16;
  localparam int unsigned PORCH_LINES_DEF = 8;
  // Gamma trim register indices
  localparam logic [15:0] GAMMA_FIRST_IDX = 16'h0300;
  localparam logic [15:0] GAMMA_NEG_IDX = 16'h0308;
  localparam logic [15:0] GAMMA_LAST_IDX = 16'h03F0;
  localparam int unsigned GAMMA_WORDS = 8;
  localparam int unsigned GAMMA_FIELDS = 16;
  localparam int unsigned TRIM_LO_BIT = 0;
  localparam int unsigned TRIM_HI_BIT = 8;
  localparam logic [5:0] TRIM_RESET = 6'h00;

  // Gate order selected by {interlace_scan_select, gate_scan_reverse}
  typedef enum logic [1:0] {
    SCAN_ASC = 2'b00,
    SCAN_DESC = 2'b01,
    SCAN_ILACE_ASC = 2'b10,
    SCAN_ILACE_DESC = 2'b11
  } scan_order_t;

  // Frame phase
  typedef enum logic [0:0] {
    PH_ACTIVE = 1'b0,
    PH_PORCH = 1'b1
  } frame_phase_t;

  typedef struct packed {
    logic interlace_scan_select;
    logic gate_scan_reverse;
    logic [5:0] active_line_count;
  } scan_cfg_t;

  typedef struct packed {
    logic [8:0] marker_line_position;
    logic [2:0] marker_repeat_interval;
  } marker_cfg_t;

  typedef struct packed {
    logic base_image_enable;
    logic window_one_enable;
    logic window_two_enable;
    logic [8:0] base_start_line;
    logic [8:0] base_end_line;
    logic [8:0] window_one_start_line;
    logic [8:0] window_one_end_line;
    logic [8:0] window_one_screen_pos;
    logic [8:0] window_two_start_line;
    logic [8:0] window_two_end_line;
    logic [8:0] window_two_screen_pos;
  } part_cfg_t;

  typedef struct packed {
    logic [8:0] gate_line;
    logic shown;
    logic [8:0] source_line;
  } line_info_t;

  // Width mask of each trim field, levels 0,1,2,61,62,63,13,50 then eight 4-bit ones
  function automatic logic [5:0] trim_mask(input logic [3:0] idx);
    case (idx)
      4'h0, 4'h5, 4'h6, 4'h7: trim_mask = 6'h1F;
      4'h1, 4'h2, 4'h3, 4'h4: trim_mask = 6'h3F;
      default: trim_mask = 6'h0F;
    endcase
  endfunction : trim_mask
endpackage : panel_scan_pkg
`default_nettype wire
